/* File: verilog/pdo_defines.svh */
`ifndef PDO_DEFINES_SVH
`define PDO_DEFINES_SVH
`define RX_MAP_BASE   16'h1600
`define TX_MAP_BASE   16'h1a00
`define RX_ASSIGN_IDX 16'h1c12
`define TX_ASSIGN_IDX 16'h1c13
`define MAX_ENTRIES   4'ha
`define ENT_IDX_MSB   31
`define ENT_IDX_LSB   16
`define ENT_SUB_MSB   15
`define ENT_SUB_LSB   8
`define ENT_LEN_MSB   7
`define ENT_LEN_LSB   0
`define EMCY_CODE     16'hff00
`define EMCY_BYTES    4'h8
`define OBJ_CTRLWORD  16'h6040
`define OBJ_STATWORD  16'h6041
`define OBJ_TGT_POS   16'h607a
`define OBJ_TGT_SPD   16'h60ff
`define OBJ_TGT_TRQ   16'h6071
`define OBJ_ACT_POS   16'h6064
`define OBJ_ACT_TRQ   16'h6077
`define OBJ_OP_MODE   16'h6060
`define OBJ_TP_FUNC   16'h60b8
`define FREERUN_NS    1000000
`define CLK_NS        5
`define FREERUN_CYC   (`FREERUN_NS / `CLK_NS)
`endif

/* File: verilog/pdo_pkg.sv */
package pdo_pkg;
  typedef enum logic [1:0] {
    ESM_PREOP  = 2'h0,
    ESM_SAFEOP = 2'h1,
    ESM_OP     = 2'h2
  } esm_t;
  typedef enum logic [1:0] {
    CFG_MAP   = 2'h0,
    CFG_ASSGN = 2'h1,
    CFG_SYNC  = 2'h2,
    CFG_DFLT  = 2'h3
  } cfg_kind_t;
endpackage

/* File: verilog/pdo_link_if.sv */
`timescale 1ns/1ps
// configuration, cyclic image and mailbox signals between master and drive
interface pdo_link_if;
  logic              cfg_valid;
  pdo_pkg::cfg_kind_t cfg_kind;
  logic              cfg_tx;
  logic [1:0]        cfg_map;
  logic [3:0]        cfg_sub;
  logic [31:0]       cfg_data;
  logic              cfg_ack;
  logic              cfg_err;
  logic [15:0]       attr_idx;
  logic              attr_mappable;
  pdo_pkg::esm_t     state;
  logic              cycle_valid;
  logic [255:0]      rx_image;
  logic              rx_image_valid;
  logic [511:0]      tx_image;
  logic [15:0]       tx_bits;
  logic              tx_image_valid;
  logic              mbx_valid;
  logic [7:0]        mbx_byte;
  logic              mbx_last;
  logic              mbx_ready;
  modport drive (input cfg_valid, cfg_kind, cfg_tx, cfg_map, cfg_sub, cfg_data, attr_idx,
                 state, cycle_valid, rx_image, mbx_ready,
                 output cfg_ack, cfg_err, attr_mappable, rx_image_valid, tx_image, tx_bits,
                 tx_image_valid, mbx_valid, mbx_byte, mbx_last);
  modport master (output cfg_valid, cfg_kind, cfg_tx, cfg_map, cfg_sub, cfg_data, attr_idx,
                  state, cycle_valid, rx_image, mbx_ready,
                  input cfg_ack, cfg_err, attr_mappable, rx_image_valid, tx_image, tx_bits,
                  tx_image_valid, mbx_valid, mbx_byte, mbx_last);
endinterface // pdo_link_if

/* File: verilog/pdo_drive.sv */
`timescale 1ns/1ps
`include "pdo_defines.svh"
// drive end: mapping tables, image packing, sync select, emergency sender
module pdo_drive #(
  parameter int FREERUN_CYCLES = `FREERUN_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  pdo_link_if.drive        lnk,
  input  wire logic        sync0_pin,
  input  wire logic        alarm,
  input  wire logic [15:0] alarm_code,
  input  wire logic [7:0]  err_reg,
  input  wire logic [15:0] obj_sel_val,
  output logic [15:0]      obj_sel_idx,
  output logic             proc_tick,
  output logic             dc_mode,
  output logic [255:0]     rx_data,
  output logic             rx_data_valid
);
  // ------------------------------------------------------------
  // mapping tables
  // ------------------------------------------------------------
  logic [31:0] rx_ent_q [4][10];
  logic [31:0] tx_ent_q [4][10];
  logic [3:0]  rx_cnt_q [4];
  logic [3:0]  tx_cnt_q [4];
  logic [3:0]  rx_asg_q, tx_asg_q;    // bit per mapping carried by the channel
  logic        dc_q;
  logic        ack_q, err_q, attr_q;

  // object may appear in a mapping
  function automatic logic mappable(input logic [15:0] idx);
    mappable = (idx[15:12] == 4'h6) || (idx[15:8] == 8'h26);
  endfunction

  // default set builder
  function automatic logic [31:0] ent(input logic [15:0] idx, input logic [7:0] bits);
    ent = {idx, 8'h00, bits};
  endfunction

  always_ff @(posedge clk_sys) begin
    ack_q  <= 1'b0;
    err_q  <= 1'b0;
    attr_q <= mappable(lnk.attr_idx);
    if (!nrst) begin
      rx_asg_q <= 4'h1;
      tx_asg_q <= 4'h1;
      dc_q     <= 1'b0;
      for (int m = 0; m < 4; m++) begin
        rx_cnt_q[m] <= 4'h0;
        tx_cnt_q[m] <= 4'h0;
        for (int e = 0; e < 10; e++) begin
          rx_ent_q[m][e] <= 32'h0;
          tx_ent_q[m][e] <= 32'h0;
        end
      end
    end else if (lnk.cfg_valid) begin
      ack_q <= 1'b1;
      case (lnk.cfg_kind)
        pdo_pkg::CFG_MAP: begin
          if (lnk.cfg_sub == 4'h0) begin
            if (lnk.cfg_data[3:0] > `MAX_ENTRIES || lnk.cfg_data[31:4] != 28'h0)
              err_q <= 1'b1;
            else if (lnk.cfg_tx) tx_cnt_q[lnk.cfg_map] <= lnk.cfg_data[3:0];
            else rx_cnt_q[lnk.cfg_map] <= lnk.cfg_data[3:0];
          end else if (lnk.cfg_sub > `MAX_ENTRIES ||
                       !mappable(lnk.cfg_data[`ENT_IDX_MSB:`ENT_IDX_LSB])) begin
            err_q <= 1'b1;
          end else if (lnk.cfg_tx) begin
            tx_ent_q[lnk.cfg_map][lnk.cfg_sub - 4'h1] <= lnk.cfg_data;
          end else begin
            rx_ent_q[lnk.cfg_map][lnk.cfg_sub - 4'h1] <= lnk.cfg_data;
          end
        end
        pdo_pkg::CFG_ASSGN: begin
          if (lnk.cfg_tx) tx_asg_q <= lnk.cfg_data[3:0];
          else rx_asg_q <= lnk.cfg_data[3:0];
        end
        pdo_pkg::CFG_SYNC: dc_q <= lnk.cfg_data[0];
        default: begin
          // default sets load mapping 0 of both directions
          rx_asg_q <= 4'h1;
          tx_asg_q <= 4'h1;
          rx_ent_q[0][0] <= ent(`OBJ_CTRLWORD, 8'h10);
          tx_ent_q[0][0] <= ent(`OBJ_STATWORD, 8'h10);
          tx_ent_q[0][1] <= ent(`OBJ_ACT_POS, 8'h20);
          tx_cnt_q[0]    <= 4'h2;
          rx_cnt_q[0]    <= 4'h2;
          case (lnk.cfg_data[1:0])
            2'h0: begin
              rx_ent_q[0][1] <= ent(`OBJ_TGT_TRQ, 8'h10);
              rx_ent_q[0][2] <= ent(`OBJ_TGT_POS, 8'h20);
              rx_ent_q[0][3] <= ent(`OBJ_OP_MODE, 8'h08);
              rx_ent_q[0][4] <= ent(`OBJ_TP_FUNC, 8'h10);
              rx_cnt_q[0]    <= 4'h5;
              tx_ent_q[0][1] <= ent(`OBJ_ACT_TRQ, 8'h10);
              tx_ent_q[0][2] <= ent(`OBJ_ACT_POS, 8'h20);
              tx_cnt_q[0]    <= 4'h3;
            end
            2'h1: rx_ent_q[0][1] <= ent(`OBJ_TGT_POS, 8'h20);
            2'h2: rx_ent_q[0][1] <= ent(`OBJ_TGT_SPD, 8'h20);
            default: rx_ent_q[0][1] <= ent(`OBJ_TGT_TRQ, 8'h10);
          endcase
        end
      endcase
    end
  end

  assign lnk.cfg_ack       = ack_q;
  assign lnk.cfg_err       = err_q;
  assign lnk.attr_mappable = attr_q;

  // ------------------------------------------------------------
  // sync0 input and processing tick
  // ------------------------------------------------------------
  logic [2:0]  s0_q;
  logic        s0_lvl_q;
  logic [31:0] fr_cnt_q;
  logic        tick_q;
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s0_q     <= 3'h0;
      s0_lvl_q <= 1'b0;
    end else begin
      s0_q <= {s0_q[1:0], sync0_pin};
      if (s0_q[1] == s0_q[2]) s0_lvl_q <= s0_q[2];
    end
  end

  // free-run timer or sync0 edge starts a cycle
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      fr_cnt_q <= 32'h0;
      tick_q   <= 1'b0;
    end else if (dc_q) begin
      fr_cnt_q <= 32'h0;
      tick_q   <= (s0_q[1] == s0_q[2]) && s0_q[2] && !s0_lvl_q;
    end else begin
      tick_q   <= (fr_cnt_q == 32'(FREERUN_CYCLES - 1));
      fr_cnt_q <= (fr_cnt_q == 32'(FREERUN_CYCLES - 1)) ? 32'h0 : fr_cnt_q + 32'h1;
    end
  end
  assign proc_tick = tick_q;
  assign dc_mode   = dc_q;

  // ------------------------------------------------------------
  // tx image packing, one entry per clock in ascending order
  // ------------------------------------------------------------
  logic [1:0]   pm_q;
  logic [3:0]   pe_q;
  logic         busy_q;
  logic [511:0] img_q;
  logic [15:0]  bits_q;
  logic         txv_q;
  logic [31:0]  cur;
  logic         pm_last;
  always_comb begin
    cur     = tx_ent_q[pm_q][pe_q];
    pm_last = (tx_asg_q >> (pm_q + 2'h1)) == 4'h0 || pm_q == 2'h3;
  end
  assign obj_sel_idx = cur[`ENT_IDX_MSB:`ENT_IDX_LSB];

  always_ff @(posedge clk_sys) begin
    txv_q <= 1'b0;
    if (!nrst) begin
      pm_q <= 2'h0; pe_q <= 4'h0; busy_q <= 1'b0;
      img_q <= 512'h0; bits_q <= 16'h0;
    end else if (!busy_q) begin
      if (tick_q && lnk.state != pdo_pkg::ESM_PREOP) begin
        busy_q <= 1'b1; pm_q <= 2'h0; pe_q <= 4'h0;
        img_q  <= 512'h0; bits_q <= 16'h0;
      end
    end else begin
      if (tx_asg_q[pm_q] && pe_q < tx_cnt_q[pm_q]) begin
        // lsb-first append at the running bit offset
        img_q  <= img_q | ((512'(obj_sel_val) & ((512'h1 << cur[`ENT_LEN_MSB:`ENT_LEN_LSB])
                  - 512'h1)) << bits_q);
        bits_q <= bits_q + 16'(cur[`ENT_LEN_MSB:`ENT_LEN_LSB]);
        pe_q   <= pe_q + 4'h1;
      end else if (pm_last) begin
        busy_q <= 1'b0;
        txv_q  <= 1'b1;
      end else begin
        pm_q <= pm_q + 2'h1;  // next mapping index in the channel, assigned or not
        pe_q <= 4'h0;
      end
    end
  end
  assign lnk.tx_image       = img_q;
  assign lnk.tx_bits        = bits_q;
  assign lnk.tx_image_valid = txv_q;

  // ------------------------------------------------------------
  // rx image accepted only in operational
  // ------------------------------------------------------------
  logic [255:0] rxd_q;
  logic         rxv_q;
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rxd_q <= 256'h0;
      rxv_q <= 1'b0;
    end else begin
      rxv_q <= lnk.cycle_valid && lnk.state == pdo_pkg::ESM_OP;
      if (lnk.cycle_valid && lnk.state == pdo_pkg::ESM_OP) rxd_q <= lnk.rx_image;
    end
  end
  assign rx_data            = rxd_q;
  assign rx_data_valid      = rxv_q;
  assign lnk.rx_image_valid = rxv_q;

  // ------------------------------------------------------------
  // emergency message over mailbox
  // ------------------------------------------------------------
  logic        al_q, pend_q, snd_q;
  logic [3:0]  bi_q;
  logic [63:0] msg_q;
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      al_q <= 1'b0; pend_q <= 1'b0; snd_q <= 1'b0;
      bi_q <= 4'h0; msg_q <= 64'h0;
    end else begin
      al_q <= alarm;
      if (alarm && !al_q) begin
        pend_q <= 1'b1;
        // byte 0 first: code lsb, code msb, err reg, 0, alarm lsb, msb, 0, 0
        msg_q  <= {16'h0000, alarm_code, 8'h00, err_reg, `EMCY_CODE};
      end
      if (!snd_q && pend_q) begin
        snd_q <= 1'b1; bi_q <= 4'h0; pend_q <= alarm && !al_q;
      end else if (snd_q && lnk.mbx_ready) begin
        bi_q <= bi_q + 4'h1;
        if (bi_q == `EMCY_BYTES - 4'h1) snd_q <= 1'b0;
      end
    end
  end
  assign lnk.mbx_valid = snd_q;
  assign lnk.mbx_byte  = msg_q[8*bi_q[2:0] +: 8];
  assign lnk.mbx_last  = snd_q && bi_q == `EMCY_BYTES - 4'h1;
endmodule // pdo_drive

/* File: verilog/pdo_master.sv */
`timescale 1ns/1ps
`include "pdo_defines.svh"
// master end: forwards user config, cycles data, collects emergency bytes
module pdo_master (
  input  wire logic                clk_sys,
  input  wire logic                nrst,
  pdo_link_if.master               lnk,
  input  wire logic                u_cfg_valid,
  input  wire pdo_pkg::cfg_kind_t  u_cfg_kind,
  input  wire logic                u_cfg_tx,
  input  wire logic [1:0]          u_cfg_map,
  input  wire logic [3:0]          u_cfg_sub,
  input  wire logic [31:0]         u_cfg_data,
  input  wire logic [15:0]         u_attr_idx,
  input  wire pdo_pkg::esm_t       u_state,
  input  wire logic                u_cycle,
  input  wire logic [255:0]        u_rx_image,
  output logic                     u_emcy_valid,
  output logic [63:0]              u_emcy
);
  // ------------------------------------------------------------
  // registered drive of the link
  // ------------------------------------------------------------
  logic [63:0] sh_q, em_q;
  logic        emv_q;
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      lnk.cfg_valid   <= 1'b0;
      lnk.cfg_kind    <= pdo_pkg::CFG_MAP;
      lnk.cfg_tx      <= 1'b0;
      lnk.cfg_map     <= 2'h0;
      lnk.cfg_sub     <= 4'h0;
      lnk.cfg_data    <= 32'h0;
      lnk.attr_idx    <= 16'h0;
      lnk.state       <= pdo_pkg::ESM_PREOP;
      lnk.cycle_valid <= 1'b0;
      lnk.rx_image    <= 256'h0;
    end else begin
      // never more than ten entries are sent
      lnk.cfg_valid   <= u_cfg_valid && !(u_cfg_kind == pdo_pkg::CFG_MAP &&
                         u_cfg_sub > `MAX_ENTRIES);
      lnk.cfg_kind    <= u_cfg_kind;
      lnk.cfg_tx      <= u_cfg_tx;
      lnk.cfg_map     <= u_cfg_map;
      lnk.cfg_sub     <= u_cfg_sub;
      lnk.cfg_data    <= u_cfg_data;
      lnk.attr_idx    <= u_attr_idx;
      lnk.state       <= u_state;
      lnk.cycle_valid <= u_cycle;
      lnk.rx_image    <= u_rx_image;
    end
  end

  // emergency is best effort and only reported when complete
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      lnk.mbx_ready <= 1'b0;
      sh_q <= 64'h0; em_q <= 64'h0; emv_q <= 1'b0;
    end else begin
      lnk.mbx_ready <= 1'b1;
      emv_q <= 1'b0;
      if (lnk.mbx_valid && lnk.mbx_ready) begin
        sh_q <= {lnk.mbx_byte, sh_q[63:8]};
        if (lnk.mbx_last) begin
          em_q  <= {lnk.mbx_byte, sh_q[63:8]};
          emv_q <= 1'b1;
        end
      end
    end
  end
  assign u_emcy_valid = emv_q;
  assign u_emcy       = em_q;
endmodule // pdo_master

/* File: sim/pdo_link_assertions.sv */
`timescale 1ns/1ps
// ----------------------------------------
// link checker between master and drive
// ----------------------------------------
module pdo_link_assertions (
  input wire logic               clk_sys,
  input wire logic               nrst,
  input wire logic               cfg_valid,
  input wire pdo_pkg::cfg_kind_t cfg_kind,
  input wire logic [3:0]         cfg_sub,
  input wire logic [31:0]        cfg_data,
  input wire logic               cfg_ack,
  input wire logic               cfg_err,
  input wire logic [15:0]        attr_idx,
  input wire logic               attr_mappable,
  input wire pdo_pkg::esm_t      state,
  input wire logic               cycle_valid,
  input wire logic               rx_image_valid,
  input wire logic               mbx_valid,
  input wire logic [7:0]         mbx_byte,
  input wire logic               mbx_last,
  input wire logic               mbx_ready
);
  logic [3:0] byte_cnt_q;
  logic       mappable_w;

  // rule of thumb for mappable objects
  assign mappable_w = (attr_idx[15:12] == 4'h6) || (attr_idx[15:8] == 8'h26);

  // counts emergency bytes handed over
  always_ff @(posedge clk_sys) begin
    if (!nrst || (mbx_valid && mbx_ready && mbx_last)) begin
      byte_cnt_q <= 4'h0;
    end else if (mbx_valid && mbx_ready) begin
      byte_cnt_q <= byte_cnt_q + 4'h1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  chk_ack_one_cycle: assert property (cfg_valid |=> cfg_ack)
    else $error("config request without ack");
  chk_ack_has_cause: assert property (cfg_ack |-> $past(cfg_valid))
    else $error("ack without request");
  chk_err_with_ack: assert property (cfg_err |-> cfg_ack)
    else $error("error without ack");
  // the master side never sends an entry beyond the tenth
  chk_sub_over_err: assert property (cfg_valid && cfg_kind == pdo_pkg::CFG_MAP
    |-> cfg_sub <= 4'ha) else $error("subindex above ten sent");
  chk_count_over_err: assert property (cfg_valid && cfg_kind == pdo_pkg::CFG_MAP
    && cfg_sub == 4'h0 && cfg_data > 32'ha |=> cfg_err) else $error("count above ten accepted");
  chk_attr_value: assert property ($past(nrst) |-> attr_mappable == $past(mappable_w))
    else $error("mappable attribute wrong");
  chk_rx_op_only: assert property (rx_image_valid |-> $past(cycle_valid)
    && $past(state) == pdo_pkg::ESM_OP) else $error("rx image taken outside op");
  chk_rx_in_op: assert property (cycle_valid && state == pdo_pkg::ESM_OP
    |=> rx_image_valid) else $error("rx image not taken in op");
  chk_emcy_eight: assert property (mbx_valid && mbx_last |-> byte_cnt_q == 4'h7)
    else $error("emergency length not eight");
  chk_emcy_code: assert property (mbx_valid && byte_cnt_q < 4'h2
    |-> mbx_byte == (byte_cnt_q == 4'h0 ? 8'h00 : 8'hff)) else $error("emergency code wrong");
  chk_emcy_resv: assert property (mbx_valid && (byte_cnt_q == 4'h3 || byte_cnt_q > 4'h5)
    |-> mbx_byte == 8'h00) else $error("reserved byte not zero");
  chk_mbx_hold: assert property (mbx_valid && !mbx_ready
    |=> mbx_valid && $stable(mbx_byte)) else $error("mailbox byte dropped");

  cov_refused: cover property (cfg_valid ##1 cfg_err);
  cov_emcy: cover property (mbx_valid && mbx_last);
  cov_rx: cover property (rx_image_valid);
endmodule // pdo_link_assertions

/* File: sim/process_data_mapping_sync_emcy_tb.sv */
`timescale 1ns/1ps
module process_data_mapping_sync_emcy_tb;
  localparam int FR = 20;
  logic               clk_sys = 1'b0;
  logic               nrst, sync0_pin, alarm, u_cfg_valid, u_cfg_tx, u_cycle;
  logic [15:0]        alarm_code, obj_sel_val, obj_sel_idx, u_attr_idx;
  logic [7:0]         err_reg;
  logic               proc_tick, dc_mode, rx_data_valid, u_emcy_valid;
  logic [255:0]       rx_data, u_rx_image;
  logic [1:0]         u_cfg_map;
  logic [3:0]         u_cfg_sub;
  logic [31:0]        u_cfg_data;
  logic [63:0]        u_emcy, ev;
  pdo_pkg::cfg_kind_t u_cfg_kind;
  pdo_pkg::esm_t      u_state;
  int                 n_errors, samples_checked, n, i, j, bits_q[$], emcy_q[$];
  logic [15:0]        idx_tab[4] = '{16'h6040, 16'h2601, 16'h1000, 16'h1c12};

  pdo_link_if lnk ();
  pdo_drive #(.FREERUN_CYCLES(FR)) i_pdo_drive (.clk_sys(clk_sys), .nrst(nrst), .lnk(lnk),
    .sync0_pin(sync0_pin), .alarm(alarm), .alarm_code(alarm_code), .err_reg(err_reg),
    .obj_sel_val(obj_sel_val), .obj_sel_idx(obj_sel_idx), .proc_tick(proc_tick),
    .dc_mode(dc_mode), .rx_data(rx_data), .rx_data_valid(rx_data_valid));
  pdo_master i_pdo_master (.clk_sys(clk_sys), .nrst(nrst), .lnk(lnk),
    .u_cfg_valid(u_cfg_valid), .u_cfg_kind(u_cfg_kind), .u_cfg_tx(u_cfg_tx),
    .u_cfg_map(u_cfg_map), .u_cfg_sub(u_cfg_sub), .u_cfg_data(u_cfg_data),
    .u_attr_idx(u_attr_idx), .u_state(u_state), .u_cycle(u_cycle), .u_rx_image(u_rx_image),
    .u_emcy_valid(u_emcy_valid), .u_emcy(u_emcy));
  pdo_link_assertions i_chk (.clk_sys(clk_sys), .nrst(nrst), .cfg_valid(lnk.cfg_valid),
    .cfg_kind(lnk.cfg_kind), .cfg_sub(lnk.cfg_sub), .cfg_data(lnk.cfg_data),
    .cfg_ack(lnk.cfg_ack), .cfg_err(lnk.cfg_err), .attr_idx(lnk.attr_idx),
    .attr_mappable(lnk.attr_mappable), .state(lnk.state), .cycle_valid(lnk.cycle_valid),
    .rx_image_valid(lnk.rx_image_valid), .mbx_valid(lnk.mbx_valid), .mbx_byte(lnk.mbx_byte),
    .mbx_last(lnk.mbx_last), .mbx_ready(lnk.mbx_ready));

  // clock and object values seen by the packer
  always #2.5 clk_sys = ~clk_sys;
  assign obj_sel_val = obj_sel_idx ^ 16'h5a5a;

  // compares one result and counts it
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one configuration request, waits for its ack
  task automatic cfg(input pdo_pkg::cfg_kind_t k, input logic t, input logic [1:0] m,
                     input logic [3:0] s, input logic [31:0] d, input logic e);
    @(posedge clk_sys);
    {u_cfg_valid, u_cfg_kind, u_cfg_tx, u_cfg_map, u_cfg_sub, u_cfg_data} <= {1'b1, k, t, m, s, d};
    @(posedge clk_sys);
    u_cfg_valid <= 1'b0;
    for (int k2 = 0; k2 < 8 && lnk.cfg_ack !== 1'b1; k2++) begin
      @(posedge clk_sys);
      #1;
    end
    check({63'h0, lnk.cfg_ack}, {63'h0, !(k == pdo_pkg::CFG_MAP && s > 4'ha)});
    check({63'h0, lnk.cfg_err}, {63'h0, e});
  endtask

  // cycles until the next processing tick
  task automatic wait_tick(output int c);
    for (c = 1; c < 100; c++) begin
      @(posedge clk_sys);
      #1;
      if (proc_tick === 1'b1) break;
    end
  endtask

  // skips one image and waits for a fresh one
  task automatic tx_fresh();
    repeat (2) for (int c = 0; c < 100; c++) begin
      @(posedge clk_sys);
      #1;
      if (lnk.tx_image_valid === 1'b1) break;
    end
  endtask

  // one cyclic frame from the master
  task automatic frame(output int seen);
    @(posedge clk_sys);
    u_cycle <= 1'b1;
    @(posedge clk_sys);
    u_cycle <= 1'b0;
    seen = 0;
    repeat (6) begin
      @(posedge clk_sys);
      #1;
      if (rx_data_valid === 1'b1) seen++;
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  initial begin
    #(20000 * 5);
    n_errors++;
    tally_and_finish();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {nrst, sync0_pin, alarm, u_cfg_valid, u_cfg_tx, u_cycle, u_cfg_map, u_cfg_sub} = '0;
    {alarm_code, err_reg, u_attr_idx, u_cfg_data, u_rx_image} = '0;
    u_cfg_kind = pdo_pkg::CFG_MAP;
    u_state = pdo_pkg::ESM_PREOP;
    void'($urandom(99));
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    wait_tick(n);
    wait_tick(n);
    check(64'(n), 64'(FR));
    foreach (idx_tab[k]) begin
      @(posedge clk_sys);
      u_attr_idx <= idx_tab[k];
      repeat (3) @(posedge clk_sys);
      #1;
      check({63'h0, lnk.attr_mappable}, 64'(k < 2));
    end
    // an eleventh entry is withheld by the master, so no ack and no error
    cfg(pdo_pkg::CFG_MAP, 1'b1, 2'h1, 4'hb, 32'h60770010, 1'b0);
    cfg(pdo_pkg::CFG_MAP, 1'b1, 2'h1, 4'h0, 32'h0000000b, 1'b1);
    cfg(pdo_pkg::CFG_MAP, 1'b1, 2'h1, 4'h1, 32'h10000010, 1'b1);
    cfg(pdo_pkg::CFG_DFLT, 1'b0, 2'h0, 4'h0, 32'h0, 1'b0);
    @(posedge clk_sys);
    u_state <= pdo_pkg::ESM_SAFEOP;
    bits_q = '{16, 32};
    for (i = 3; i > 0; i--) begin
      cfg(pdo_pkg::CFG_DFLT, 1'b0, 2'h0, 4'h0, 32'(i), 1'b0);
      tx_fresh();
      check(64'(lnk.tx_bits), 64'(bits_q.sum()));
      check(64'(lnk.tx_image[15:0]), 64'(16'h6041 ^ 16'h5a5a));
    end
    cfg(pdo_pkg::CFG_MAP, 1'b1, 2'h1, 4'h1, 32'h60770010, 1'b0);
    cfg(pdo_pkg::CFG_MAP, 1'b1, 2'h1, 4'h0, 32'h00000001, 1'b0);
    cfg(pdo_pkg::CFG_ASSGN, 1'b1, 2'h0, 4'h0, 32'h00000003, 1'b0);
    bits_q.push_back(16);
    tx_fresh();
    check(64'(lnk.tx_bits), 64'(bits_q.sum()));
    check(64'(lnk.tx_image[63:48]), 64'(16'h6077 ^ 16'h5a5a));
    @(posedge clk_sys);
    u_rx_image <= {8{$urandom()}};
    frame(n);
    check(64'(n), 64'h0);
    @(posedge clk_sys);
    u_state <= pdo_pkg::ESM_OP;
    repeat (3) @(posedge clk_sys);
    frame(n);
    check(64'(n), 64'h1);
    for (j = 0; j < 4; j++) check(rx_data[j*64 +: 64], u_rx_image[j*64 +: 64]);
    cfg(pdo_pkg::CFG_SYNC, 1'b0, 2'h0, 4'h0, 32'h1, 1'b0);
    check({63'h0, dc_mode}, 64'h1);
    @(posedge clk_sys);
    sync0_pin <= 1'b1;
    wait_tick(n);
    check(64'(n), 64'h4);
    @(posedge clk_sys);
    sync0_pin <= 1'b0;
    cfg(pdo_pkg::CFG_SYNC, 1'b0, 2'h0, 4'h0, 32'h0, 1'b0);
    check({63'h0, dc_mode}, 64'h0);
    repeat (2) begin
      @(posedge clk_sys);
      alarm_code <= 16'($urandom());
      err_reg    <= 8'($urandom());
      @(posedge clk_sys);
      emcy_q = '{0, 255, err_reg, 0, alarm_code[7:0], alarm_code[15:8], 0, 0};
      alarm <= 1'b1;
      // bounded wait, delivery is never taken for granted
      for (n = 0; n < 60 && u_emcy_valid !== 1'b1; n++) begin
        @(posedge clk_sys);
        #1;
      end
      for (j = 0; j < 8; j++) ev[j*8 +: 8] = 8'(emcy_q.pop_front());
      check(u_emcy, ev);
      @(posedge clk_sys);
      alarm <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
    tally_and_finish();
  end
endmodule // process_data_mapping_sync_emcy_tb
